// ---- rtl/vidreg_cfg.svh ----
// Register offsets, field positions and reset values of the voltage-id register bank.
`ifndef VIDREG_CFG_SVH
`define VIDREG_CFG_SVH

`define VIDREG_ADDR_W          3
`define VIDREG_OFF_CC_ONE      3'h0
`define VIDREG_OFF_CC_TWO      3'h1
`define VIDREG_OFF_CC_THREE    3'h2
`define VIDREG_OFF_FUSE_LOW    3'h3
`define VIDREG_OFF_FUSE_HIGH   3'h4
`define VIDREG_OFF_SNAPSHOT    3'h5

`define VIDREG_BIT_START       0
`define VIDREG_BIT_SENSE_EN    1
`define VIDREG_BIT_DYN_AVS     0
`define VIDREG_STEP_LSB        21
`define VIDREG_STEP_MSB        26
`define VIDREG_DELAY_LSB       1
`define VIDREG_DELAY_MSB       20

`define VIDREG_RST_START       1'h0
`define VIDREG_RST_SENSE_EN    1'h1
`define VIDREG_RST_DYN_AVS     1'h1
`define VIDREG_RST_STEP        6'h01
`define VIDREG_RST_DELAY       20'h02710
`define VIDREG_RST_CC_THREE    32'h0000_0000

`define VIDREG_TEMP_W          10
`define VIDREG_CODE_W          6
`define VIDREG_SNAP_CODE_LSB   16

`endif

// ---- rtl/vidreg_pkg.sv ----
// Types shared by the voltage-id register bank.
package vidreg_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [2:0]  address;
    logic [31:0] writedata;
  } vidreg_bus_req_t;

  typedef struct packed {
    logic        start;
    logic        sense_en;
    logic        dyn_avs;
    logic [5:0]  step;
    logic [19:0] delay;
    logic [31:0] cc_three;
  } vidreg_ctrl_t;

  typedef enum logic [2:0] {
    VIDREG_IDLE  = 3'b001,
    VIDREG_FUSE  = 3'b010,
    VIDREG_RUN   = 3'b100
  } vidreg_state_t;

endpackage : vidreg_pkg

// ---- rtl/vidreg_bank.sv ----
// Control and status register bank of the voltage-id controller.
`timescale 1ns/1ns
`include "vidreg_cfg.svh"

module vidreg_bank #(
  parameter int FUSE_W = 64
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire vidreg_pkg::vidreg_bus_req_t bus_i,
  output logic [31:0]                    readdata_o,
  input  wire logic [FUSE_W-1:0]         fuse_value_i,
  input  wire logic                      fuse_done_i,
  input  wire logic [`VIDREG_TEMP_W-1:0] temp_code_i,
  input  wire logic                      temp_valid_i,
  input  wire logic [`VIDREG_CODE_W-1:0] vid_code_i,
  input  wire logic                      vid_code_valid_i,
  input  wire logic                      interval_start_i,
  output logic                           fuse_read_req_o,
  output logic                           running_o,
  output logic                           temp_sense_enable_o,
  output vidreg_pkg::vidreg_ctrl_t       ctrl_o
);
  import vidreg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Software-visible control registers.
  // Start and sensor enable sit in the first control word; scaling enable, delay
  // and step size sit in the second.
  logic                      start_r;
  logic                      sense_en_r;
  logic                      dyn_avs_r;
  logic [5:0]                step_r;
  logic [19:0]               delay_r;
  logic [FUSE_W-1:0]         fuse_r;
  logic [`VIDREG_TEMP_W-1:0] temp_r;
  logic [`VIDREG_CODE_W-1:0] code_r;
  vidreg_ctrl_t              live_ctrl;
  vidreg_ctrl_t              shadow_r;
  vidreg_state_t             state_r;
  logic                      wr_cc_one;
  logic                      wr_cc_two;

  // Single-cycle writes with full-word data; no byte lanes exist.
  // Reserved bits have no storage at all, so a write can never reach them.
  // Offsets 0x2 to 0x7 have no write decode, so writes there fall away unseen.
  assign wr_cc_one = bus_i.write && (bus_i.address == `VIDREG_OFF_CC_ONE);
  assign wr_cc_two = bus_i.write && (bus_i.address == `VIDREG_OFF_CC_TWO);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      start_r    <= `VIDREG_RST_START;
      sense_en_r <= `VIDREG_RST_SENSE_EN;
    end else if (wr_cc_one) begin
      start_r    <= bus_i.writedata[`VIDREG_BIT_START];
      sense_en_r <= bus_i.writedata[`VIDREG_BIT_SENSE_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dyn_avs_r <= `VIDREG_RST_DYN_AVS;
      step_r    <= `VIDREG_RST_STEP;
      delay_r   <= `VIDREG_RST_DELAY;
    end else if (wr_cc_two) begin
      dyn_avs_r <= bus_i.writedata[`VIDREG_BIT_DYN_AVS];
      step_r    <= bus_i.writedata[`VIDREG_STEP_MSB:`VIDREG_STEP_LSB];
      delay_r   <= bus_i.writedata[`VIDREG_DELAY_MSB:`VIDREG_DELAY_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status captured from the controller core.
  // Each word is taken whenever its valid pulse arrives, whatever the state, so a
  // read always returns the last value the core reported; the fuse words read
  // zero until the first fetch completes.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fuse_r <= '0;
    end else if (fuse_done_i) begin
      fuse_r <= fuse_value_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      temp_r <= '0;
    end else if (temp_valid_i) begin
      temp_r <= temp_code_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_r <= '0;
    end else if (vid_code_valid_i) begin
      code_r <= vid_code_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start sequence: wait for the start bit, fetch fuses, then run.
  // Clearing the start bit while running drops back to idle, so setting it again fetches the
  // fuses afresh before the controller runs once more.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= VIDREG_IDLE;
    end else begin
      case (state_r)
        VIDREG_IDLE: begin
          if (start_r) begin
            state_r <= VIDREG_FUSE;
          end
        end
        VIDREG_FUSE: begin
          if (fuse_done_i) begin
            state_r <= VIDREG_RUN;
          end
        end
        VIDREG_RUN: begin
          if (!start_r) begin
            state_r <= VIDREG_IDLE;
          end
        end
        default: begin
          // An illegal state code falls back to idle rather than guessing.
          state_r <= VIDREG_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs towards the controller core and the temperature sensor.
  assign fuse_read_req_o     = (state_r == VIDREG_FUSE);
  assign running_o           = (state_r == VIDREG_RUN);
  assign temp_sense_enable_o = sense_en_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Control shadow, refreshed only at interval boundaries or while not running (idle or fetching fuses).
  // While idle the shadow follows the registers every cycle, so the first interval
  // after start already sees everything programmed beforehand; once running, a
  // write lands in the live register and waits for the next interval boundary.
  always_comb begin
    live_ctrl          = '0;
    live_ctrl.start    = start_r;
    live_ctrl.sense_en = sense_en_r;
    live_ctrl.dyn_avs  = dyn_avs_r;
    live_ctrl.step     = step_r;
    live_ctrl.delay    = delay_r;
    live_ctrl.cc_three = `VIDREG_RST_CC_THREE;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shadow_r <= '0;
    end else if (interval_start_i || (state_r != VIDREG_RUN)) begin
      shadow_r <= live_ctrl;
    end
  end

  assign ctrl_o = shadow_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational read data, valid in the same cycle as the read strobe.
  // The bus allows no wait states, so the mux is not registered: a flopped copy
  // would return data one cycle after the strobe and the master would miss it.
  // Nothing but a read strobe opens the mux, which keeps the bus quiet when idle.
  always_comb begin
    readdata_o = 32'h0000_0000;
    if (bus_i.read) begin
      case (bus_i.address)
        `VIDREG_OFF_CC_ONE: begin
          readdata_o[`VIDREG_BIT_START]    = start_r;
          readdata_o[`VIDREG_BIT_SENSE_EN] = sense_en_r;
        end
        `VIDREG_OFF_CC_TWO: begin
          readdata_o[`VIDREG_BIT_DYN_AVS]                   = dyn_avs_r;
          readdata_o[`VIDREG_DELAY_MSB:`VIDREG_DELAY_LSB]   = delay_r;
          readdata_o[`VIDREG_STEP_MSB:`VIDREG_STEP_LSB]     = step_r;
        end
        `VIDREG_OFF_CC_THREE: begin
          // The third control word has no writable field in this bank and reads as zero.
          readdata_o = `VIDREG_RST_CC_THREE;
        end
        `VIDREG_OFF_FUSE_LOW: begin
          readdata_o = fuse_r[31:0];
        end
        `VIDREG_OFF_FUSE_HIGH: begin
          readdata_o = fuse_r[63:32];
        end
        `VIDREG_OFF_SNAPSHOT: begin
          readdata_o[`VIDREG_TEMP_W-1:0] = temp_r;
          readdata_o[`VIDREG_SNAP_CODE_LSB +: `VIDREG_CODE_W] = code_r;
        end
        default: begin
          readdata_o = 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : vidreg_bank

// ---- test/vidreg_bank_properties.sv ----
// Port-level checks on the voltage-id register bank.
`timescale 1ns/1ns
module vidreg_bank_properties (
  input wire logic                        clk_i,
  input wire logic                        reset_i,
  input wire vidreg_pkg::vidreg_bus_req_t bus_i,
  input wire logic [31:0]                 readdata_o,
  input wire logic                        fuse_done_i,
  input wire logic                        interval_start_i,
  input wire logic                        fuse_read_req_o,
  input wire logic                        running_o,
  input wire logic                        temp_sense_enable_o,
  input wire vidreg_pkg::vidreg_ctrl_t    ctrl_o
);
  import vidreg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_go;
    bus_i.write && bus_i.address == 3'h0 && bus_i.writedata[0] && !running_o && !fuse_read_req_o;
  endsequence
  a_cc1_rsvd_zero: assert property (bus_i.read && bus_i.address == 3'h0 |->
    readdata_o[31:2] == 30'h0 && readdata_o[1] == temp_sense_enable_o) else $error("cc1 readback wrong");
  a_cc2_rsvd_zero: assert property (bus_i.read && bus_i.address == 3'h1 |-> readdata_o[31:27] == 5'h0)
    else $error("cc2 reserved bits set");
  a_cc3_reads_zero: assert property (bus_i.read && bus_i.address == 3'h2 |-> readdata_o == 32'h0)
    else $error("cc3 not zero");
  a_unmapped_zero: assert property (bus_i.read && bus_i.address > 3'h5 |-> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_sense_write: assert property (bus_i.write && bus_i.address == 3'h0 |=>
    temp_sense_enable_o == $past(bus_i.writedata[1])) else $error("sensor enable not written");
  a_idle_after_reset: assert property (disable iff (1'b0) reset_i |=>
    !running_o && !fuse_read_req_o && temp_sense_enable_o) else $error("not idle after reset");
  a_fuse_first: assert property (s_go |=> ##1 fuse_read_req_o) else $error("no fuse request");
  a_run_after_fuse: assert property (fuse_read_req_o && fuse_done_i |=> running_o && !fuse_read_req_o)
    else $error("no run after fuse");
  a_shadow_hold: assert property (running_o && !interval_start_i |=> $stable(ctrl_o) || !running_o)
    else $error("shadow changed mid interval");
endmodule : vidreg_bank_properties

bind vidreg_bank vidreg_bank_properties vidreg_bank_properties_inst (.clk_i, .reset_i, .bus_i, .readdata_o,
  .fuse_done_i, .interval_start_i, .fuse_read_req_o, .running_o, .temp_sense_enable_o, .ctrl_o);

// ---- test/vidreg_master.sv ----
// Bus master model issuing single full-word transfers with an idle cycle between.
`timescale 1ns/1ns
module vidreg_master (
  input  wire logic                   clk_i,
  input  wire logic [31:0]            readdata_i,
  output vidreg_pkg::vidreg_bus_req_t bus_o
);
  import vidreg_pkg::*;
  initial bus_o = '0;
  task automatic xfer(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    bus_o <= '{~w, w, a, d};
    @(posedge clk_i);
    q = readdata_i;
    bus_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask : xfer
endmodule : vidreg_master

// ---- test/vidreg_bank_tb.sv ----
// Self-checking bench for the voltage-id register bank.
`timescale 1ns/1ns
module vidreg_bank_tb;
  import vidreg_pkg::*;
  logic            clk_i = 1'b0, reset_i = 1'b1, fdone = 1'b0, tval = 1'b0, cval = 1'b0, istart = 1'b0;
  logic            freq, run, sens;
  logic [31:0]     rdata, q, old;
  logic [63:0]     fuse = '0;
  logic [9:0]      temp = '0;
  logic [5:0]      code = '0;
  vidreg_bus_req_t bus;
  vidreg_ctrl_t    ctrl;
  int              n_mismatch = 0, compares = 0, m[8], k[8] = '{32'h3, 32'h07ff_ffff, 0, 0, 0, 0, 0, 0};
  initial forever #5 clk_i = ~clk_i;
  vidreg_bank vidreg_bank_inst (.clk_i, .reset_i, .bus_i(bus), .readdata_o(rdata), .fuse_value_i(fuse),
    .fuse_done_i(fdone), .temp_code_i(temp), .temp_valid_i(tval), .vid_code_i(code), .vid_code_valid_i(cval),
    .interval_start_i(istart), .fuse_read_req_o(freq), .running_o(run), .temp_sense_enable_o(sens),
    .ctrl_o(ctrl));
  vidreg_master vidreg_master_inst (.clk_i, .readdata_i(rdata), .bus_o(bus));
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(int a, logic [31:0] d);
    vidreg_master_inst.xfer(1'b1, a[2:0], d, q);
    m[a] = d & k[a] | m[a] & ~k[a];
  endtask : wr
  function automatic logic [31:0] cc2_legal(logic [31:0] d);
    return {d[31:21], 20'h02710 + {4'h0, d[15:0]}, d[0]};
  endfunction : cc2_legal
  task automatic sweep(logic [7:0] sel);
    for (int a = 0; a < 8; a++) begin
      if (sel[a]) begin
        vidreg_master_inst.xfer(1'b0, a[2:0], '0, q);
        chk($sformatf("reg%0d", a), m[a], q);
      end
    end
  endtask : sweep
  task automatic pulse(int w);
    @(posedge clk_i);
    case (w)
      0: fdone <= 1'b1;
      1: tval <= 1'b1;
      2: cval <= 1'b1;
      default: istart <= 1'b1;
    endcase
    @(posedge clk_i);
    {fdone, tval, cval, istart} <= 4'h0;
    @(posedge clk_i);
  endtask : pulse
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'h7c75));
    m = '{32'h2, 32'h0020_4e21, 0, 0, 0, 0, 0, 0};
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    sweep(8'hc7);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) wr(i, i == 1 ? cc2_legal($urandom) : $urandom & 32'hffff_fffe);
    sweep(8'hc7);
    $display("test random writes done");
    fuse <= {$urandom, $urandom};
    temp <= 10'($urandom);
    code <= 6'($urandom);
    old = m[1];
    wr(0, 32'h3);
    for (int i = 0; i < 20 && freq !== 1'b1; i++) @(posedge clk_i);
    chk("fuse_req", 32'h1, {31'h0, freq});
    pulse(0);
    chk("running", 32'h1, {31'h0, run});
    chk("sense_en", {31'h0, m[0][1]}, {31'h0, sens});
    pulse(1);
    pulse(2);
    m[3] = fuse[31:0];
    m[4] = fuse[63:32];
    m[5] = {10'h0, code, 6'h0, temp};
    sweep(8'hff);
    $display("test start and capture done");
    wr(1, cc2_legal($urandom));
    repeat (2) @(posedge clk_i);
    chk("shadow hold", {5'h0, old[26:0]}, {5'h0, ctrl.step, ctrl.delay, ctrl.dyn_avs});
    pulse(3);
    old = m[1];
    chk("shadow load", {5'h0, old[26:0]}, {5'h0, ctrl.step, ctrl.delay, ctrl.dyn_avs});
    $display("test shadow done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
endmodule : vidreg_bank_tb
